//--- sre_map.vh
// constants for the smbus ram/eeprom command block
`ifndef SRE_MAP_VH
`define SRE_MAP_VH
// bus address and pins
`define SRE_SLAVE_HI      5'b01101
// volatile space
`define SRE_RAM_LAST      8'hdf
`define SRE_RAM_RESET     8'h00
`define SRE_UPDATE_CONFIG_OFS    8'h90
`define SRE_ERASE_EN_BIT  2
// nonvolatile space 0xf800..0xfbff, tag is address bits 15:10
`define SRE_EE_HI_FIRST   8'hf8
`define SRE_EE_HI_LAST    8'hfb
`define SRE_EE_TAG        6'h3e
`define SRE_EE_BLANK      8'hff
`define SRE_PAGE_BYTES    32
// command codes
`define SRE_CMD_BLKWR     8'hfc
`define SRE_CMD_BLKRD     8'hfd
`define SRE_CMD_ERASE     8'hfe
`define SRE_BLKRD_COUNT   8'h20
// buffering
`define SRE_FIFO_DEPTH    32
`define SRE_FIFO_AW       5
`define SRE_FIFO_W        25
// timing, clock period in ns
`define SRE_CLK_NS        4
`define SRE_PROG_US       250
`define SRE_ERASE_MS      20
`define SRE_PROG_CYC      ((`SRE_PROG_US * 1000) / `SRE_CLK_NS)
`define SRE_ERASE_CYC     ((`SRE_ERASE_MS * 1000000) / `SRE_CLK_NS)
`endif

//--- sre_master.sv
// smbus master model for the ram/eeprom block
`timescale 1ns/1ns
`default_nettype none
module sre_master (
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   output var logic  scl_oe_n,
   output var logic  sda_oe_n
);
   int smax;  // longest stretch seen
   int tmo;   // waits that ran out
   initial begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
      smax = 0;
      tmo = 0;
   end
   // quarter bit, moves only on falling clk
   task automatic q();
      repeat (8) @(negedge clk);
   endtask
   // release scl; a stretching slave may hold it, so wait bounded
   task automatic hi();
      int n;
      n = 0;
      scl_oe_n = 1'b1;
      while (!scl && n < 60000) begin
         @(negedge clk);
         n++;
      end
      if (n > smax) smax = n;
      if (n == 60000) tmo++;
      q();
   endtask
   // data set in low phase, sampled mid high phase
   task automatic bt(input logic b, output logic r);
      sda_oe_n = b;
      q();
      hi();
      r = sda;
      q();
      scl_oe_n = 1'b0;
      q();
   endtask
   // also serves as repeated start
   task automatic start();
      sda_oe_n = 1'b1;
      q();
      hi();
      sda_oe_n = 1'b0;
      q();
      scl_oe_n = 1'b0;
      q();
   endtask
   task automatic stop();
      sda_oe_n = 1'b0;
      q();
      hi();
      sda_oe_n = 1'b1;
      q();
   endtask
   // msb first, ninth bit left to the slave
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bt(d[i], r);
      bt(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bt(1'b1, r);
         d[i] = r;
      end
      bt(last, r);
   endtask
endmodule
`default_nettype wire

//--- sre_smbus_mem.v
// smbus slave command decoder with ram, eeprom and write buffer
`timescale 1ns/1ns
`default_nettype none
`include "sre_map.vh"

// flip-flop fifo, valid/ready on both sides
module sre_fifo #(
   parameter W     = 25,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire          clk,
   input  wire          srst,
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);
   reg [W-1:0] store [0:DEPTH-1];
   reg [AW:0]  wptr;
   reg [AW:0]  rptr;

   // extra pointer bit separates full from empty
   assign in_ready  = (wptr[AW-1:0] != rptr[AW-1:0]) | (wptr[AW] == rptr[AW]);
   assign out_valid = (wptr != rptr);
   assign out_data  = store[rptr[AW-1:0]];

   always @(posedge clk) begin
      if (srst) begin
         wptr <= {(AW+1){1'b0}};
         rptr <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && in_ready) begin
            store[wptr[AW-1:0]] <= in_data;
            wptr <= wptr + 1'b1;
         end
         if (out_valid && out_ready)
            rptr <= rptr + 1'b1;
      end
   end
endmodule

// Summary of operation
// - ram 0x00-0xdf, eeprom 0xf800-0xfbff decoded
// - eeprom byte stored only when blank
// - erase whole 32-byte pages only
// - erase only when update_config bit 2 set
// - send byte: address and command acknowledged
// - send byte register address loads pointer
// - 0xfe erases page from prior pointer
// - erase starts at command byte, about 20 ms
// - no acknowledge while erase in progress
// - write byte/word: every byte acknowledged
// - command 0x00-0xdf plus byte writes ram
// - 0xf8-0xfb plus byte forms eeprom pointer
// - erase ignores low five pointer bits
// - second data byte programs eeprom location
// - 0xfc block write: count, then data
// - block write crosses pages without wrapping
// - 0xfd block read returns 0x20, then bytes from the pointer until the master nacks
// - byte program ~250 us, stretch scl only while the write fifo is full or a read waits for it
// - receive byte returns byte at pointer
// - address 01101 plus two select pins
module sre_smbus_mem #(
   parameter [22:0] PROG_CYC  = `SRE_PROG_CYC,
   parameter [22:0] ERASE_CYC = `SRE_ERASE_CYC
) (
   input  wire       clk,
   input  wire       srst,
   input  wire       scl_in,
   output wire       scl_out,
   output wire       scl_oe_n,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe_n,
   input  wire [1:0] addr_sel,
   output wire       erase_busy
);
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_RX   = 3'd1;
   localparam [2:0] S_HOLD = 3'd2;
   localparam [2:0] S_ACK  = 3'd3;
   localparam [2:0] S_TX   = 3'd4;
   localparam [2:0] S_RACK = 3'd5;
   localparam       D_IDLE = 1'b0;
   localparam       D_WAIT = 1'b1;

   // pin synchronisers and edge history
   reg        scl_m;
   reg        scl_s;
   reg        scl_d;
   reg        sda_m;
   reg        sda_s;
   reg        sda_d;
   reg [1:0]  sel_m;
   reg [1:0]  sel_s;
   // protocol engine
   reg [2:0]  state;
   reg [3:0]  bitcnt;
   reg [2:0]  byte_idx;
   reg [7:0]  shreg;
   reg [7:0]  tx_byte;
   reg [7:0]  cmd;
   reg [7:0]  blk_cnt;
   reg [15:0] ptr;
   reg        rw;
   reg        blk_rd;
   reg        sda_low;
   reg        erase_pend;
   // storage and drain
   reg [7:0]  ram [0:223];
   reg [7:0]  ee  [0:1023];
   reg        dstate;
   reg [22:0] timer;
   reg        cur_erase;
   reg        erase_done;
   reg [10:0] j;
   reg [5:0]  k;
   // combinational
   reg        push_valid;
   reg [24:0] push_data;
   reg        hold_ok;
   reg [7:0]  rd_byte;
   wire       push_ready;
   wire       pop_valid;
   wire [24:0] pop_data;
   wire       scl_rise;
   wire       scl_fall;
   wire       bus_start;
   wire       bus_stop;
   wire       addr_hit;
   wire       cmd_ee;
   wire       erase_en;
   wire       ptr_in_ram;
   wire       ptr_in_ee;

   // logic reads the second and third stages, never the first
   always @(posedge clk) begin
      if (srst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         sel_m <= 2'h0;
         sel_s <= 2'h0;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         sel_m <= addr_sel;
         sel_s <= sel_m;
      end
   end

   // bus events seen on the synchronised lines
   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

   assign addr_hit   = (shreg[7:1] == {`SRE_SLAVE_HI, sel_s}) & ~erase_pend;
   assign cmd_ee     = (cmd >= `SRE_EE_HI_FIRST) && (cmd <= `SRE_EE_HI_LAST);
   assign erase_en   = ram[`SRE_UPDATE_CONFIG_OFS][`SRE_ERASE_EN_BIT];
   assign ptr_in_ram = (ptr[15:8] == 8'h00) && (ptr[7:0] <= `SRE_RAM_LAST);
   assign ptr_in_ee  = (ptr[15:10] == `SRE_EE_TAG);
   assign erase_busy = erase_pend;

   // open-drain drives: enable low pulls the line low
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~sda_low;
   assign scl_out  = 1'b0;
   assign scl_oe_n = (state != S_HOLD);

   // byte at the pointer; unmapped space reads zero
   always @* begin
      rd_byte = 8'h00;
      if (ptr_in_ram)
         rd_byte = ram[ptr[7:0]];
      else if (ptr_in_ee)
         rd_byte = ee[ptr[9:0]];
   end

   // writes queued for the drain; scl held while the queue is full
   always @* begin
      push_valid = 1'b0;
      push_data  = 25'h0;
      hold_ok    = 1'b1;
      if (state == S_HOLD) begin
         case (byte_idx)
            3'd0: begin
               // reads wait for all queued writes to land
               if (addr_hit && shreg[0])
                  hold_ok = ~pop_valid & (dstate == D_IDLE);
            end
            3'd1: begin
               if (shreg == `SRE_CMD_ERASE && erase_en) begin
                  push_valid = 1'b1;
                  push_data  = {1'b1, ptr, `SRE_EE_BLANK};
                  hold_ok    = push_ready;
               end
            end
            3'd2: begin
               if (cmd <= `SRE_RAM_LAST) begin
                  push_valid = 1'b1;
                  push_data  = {1'b0, 8'h00, cmd, shreg};
                  hold_ok    = push_ready;
               end
            end
            default: begin
               if ((cmd_ee && byte_idx == 3'd3) ||
                   (cmd == `SRE_CMD_BLKWR && blk_cnt != 8'h00)) begin
                  push_valid = 1'b1;
                  push_data  = {1'b0, ptr, shreg};
                  hold_ok    = push_ready;
               end
            end
         endcase
      end
   end

   // bit and byte engine
   always @(posedge clk) begin
      if (srst) begin
         state      <= S_IDLE;
         bitcnt     <= 4'h0;
         byte_idx   <= 3'd0;
         shreg      <= 8'h00;
         tx_byte    <= 8'h00;
         cmd        <= 8'h00;
         blk_cnt    <= 8'h00;
         ptr        <= 16'h0000;
         rw         <= 1'b0;
         blk_rd     <= 1'b0;
         sda_low    <= 1'b0;
         erase_pend <= 1'b0;
      end else begin
         // set wins over the drain's done pulse
         if (state == S_HOLD && byte_idx == 3'd1 && push_valid && push_ready)
            erase_pend <= 1'b1;
         else if (erase_done)
            erase_pend <= 1'b0;

         if (bus_start) begin
            // repeated start keeps command and block-read mode
            state    <= S_RX;
            bitcnt   <= 4'h0;
            byte_idx <= 3'd0;
            sda_low  <= 1'b0;
         end else if (bus_stop) begin
            state   <= S_IDLE;
            blk_rd  <= 1'b0;
            sda_low <= 1'b0;
         end else begin
            case (state)
               S_RX: begin
                  if (scl_rise) begin
                     shreg  <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     state  <= S_HOLD;
                     bitcnt <= 4'h0;
                  end
               end
               S_HOLD: begin
                  if (hold_ok) begin
                     state    <= S_ACK;
                     sda_low  <= 1'b1;
                     byte_idx <= (byte_idx == 3'd7) ? 3'd7 : byte_idx + 3'd1;
                     case (byte_idx)
                        3'd0: begin
                           if (!addr_hit) begin
                              state   <= S_IDLE;
                              sda_low <= 1'b0;
                           end
                           rw      <= shreg[0];
                           tx_byte <= blk_rd ? `SRE_BLKRD_COUNT : rd_byte;
                        end
                        3'd1: begin
                           cmd <= shreg;
                           if (shreg <= `SRE_RAM_LAST)
                              ptr <= {8'h00, shreg};
                           if (shreg == `SRE_CMD_BLKRD)
                              blk_rd <= 1'b1;
                        end
                        3'd2: begin
                           if (cmd_ee)
                              ptr <= {cmd, shreg};
                           if (cmd == `SRE_CMD_BLKWR)
                              blk_cnt <= shreg;
                        end
                        default: begin
                           // no page wrap: pointer runs straight on
                           if (cmd == `SRE_CMD_BLKWR && blk_cnt != 8'h00) begin
                              ptr     <= ptr + 16'h0001;
                              blk_cnt <= blk_cnt - 8'h01;
                           end
                        end
                     endcase
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     if (rw) begin
                        state   <= S_TX;
                        sda_low <= ~tx_byte[7];
                        bitcnt  <= 4'h1;
                     end else begin
                        state   <= S_RX;
                        sda_low <= 1'b0;
                        bitcnt  <= 4'h0;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        state   <= S_RACK;
                        sda_low <= 1'b0;
                     end else begin
                        sda_low <= ~tx_byte[6];
                        tx_byte <= {tx_byte[6:0], 1'b0};
                        bitcnt  <= bitcnt + 4'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise && sda_s) begin
                     state <= S_IDLE;
                  end else if (scl_fall) begin
                     // next byte from the pointer, then step it in block read
                     state   <= S_TX;
                     tx_byte <= rd_byte;
                     sda_low <= ~rd_byte[7];
                     bitcnt  <= 4'h1;
                     if (blk_rd)
                        ptr <= ptr + 16'h0001;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // write buffer between the bus and the slow array
   sre_fifo #(
      .W     (`SRE_FIFO_W),
      .DEPTH (`SRE_FIFO_DEPTH),
      .AW    (`SRE_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (pop_valid),
      .out_ready (dstate == D_IDLE),
      .out_data  (pop_data)
   );

   // drain: sole writer of ram and eeprom, owns program/erase timing
   always @(posedge clk) begin
      if (srst) begin
         dstate     <= D_IDLE;
         timer      <= 23'h0;
         cur_erase  <= 1'b0;
         erase_done <= 1'b0;
         for (j = 11'h000; j < 11'd224; j = j + 11'h001)
            ram[j[7:0]] <= `SRE_RAM_RESET;
         for (j = 11'h000; j < 11'd1024; j = j + 11'h001)
            ee[j[9:0]] <= `SRE_EE_BLANK;
      end else begin
         erase_done <= 1'b0;
         case (dstate)
            D_IDLE: begin
               if (pop_valid) begin
                  if (pop_data[24]) begin
                     // whole page; low five pointer bits ignored
                     for (k = 6'h00; k < `SRE_PAGE_BYTES; k = k + 6'h01)
                        ee[{pop_data[17:13], k[4:0]}] <= `SRE_EE_BLANK;
                     timer     <= ERASE_CYC;
                     cur_erase <= 1'b1;
                     dstate    <= D_WAIT;
                  end else if (pop_data[23:16] == 8'h00 && pop_data[15:8] <= `SRE_RAM_LAST) begin
                     ram[pop_data[15:8]] <= pop_data[7:0];
                  end else if (pop_data[23:18] == `SRE_EE_TAG) begin
                     // programmed cells keep their data until erased
                     if (ee[pop_data[17:8]] == `SRE_EE_BLANK)
                        ee[pop_data[17:8]] <= pop_data[7:0];
                     timer     <= PROG_CYC;
                     cur_erase <= 1'b0;
                     dstate    <= D_WAIT;
                  end
               end
            end
            D_WAIT: begin
               if (timer <= 23'h1) begin
                  dstate     <= D_IDLE;
                  erase_done <= cur_erase;
               end else begin
                  timer <= timer - 23'h1;
               end
            end
            default: dstate <= D_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- sre_smbus_props.sv
// assertion checker for the smbus ram/eeprom block
`timescale 1ns/1ns
`default_nettype none
module sre_smbus_props #(
   parameter [22:0] PROG_CYC  = 23'd20,
   parameter [22:0] ERASE_CYC = 23'd200
) (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe_n,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic [1:0] addr_sel,
   input wire logic       erase_busy
);
   logic [23:0] bcnt;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (srst);
   // cycles spent in the current erase
   always_ff @(posedge clk) begin
      if (srst || !erase_busy) begin
         bcnt <= 24'h0;
      end else begin
         bcnt <= bcnt + 24'h1;
      end
   end
   rst_idle_a: assert property ($fell(srst) |-> scl_oe_n && sda_oe_n && !erase_busy)
      else $error("lines held after reset");
   od_zero_a: assert property (!scl_out && !sda_out)
      else $error("open-drain value not low");
   ack_phase_a: assert property ($fell(sda_oe_n) |-> !$past(scl_in))
      else $error("sda pulled in high phase");
   rel_phase_a: assert property ($rose(sda_oe_n) |-> !$past(scl_in))
      else $error("sda released in high phase");
   stretch_low_a: assert property ($fell(scl_oe_n) |-> !$past(scl_in))
      else $error("scl pulled while high");
   erase_ack_a: assert property ($rose(erase_busy) |-> ##[0:8] !sda_oe_n)
      else $error("erase started without ack");
   erase_len_a: assert property ($fell(erase_busy) |-> bcnt >= {1'b0, ERASE_CYC})
      else $error("erase too short");
   busy_nack_a: assert property (bcnt > 24'd40 |-> !$fell(sda_oe_n))
      else $error("ack during erase");
   cover property ($rose(erase_busy));
   cover property (!scl_oe_n [*8]);
   cover property ($fell(sda_oe_n));
endmodule
bind sre_smbus_mem sre_smbus_props #(
   .PROG_CYC (PROG_CYC),
   .ERASE_CYC(ERASE_CYC)
) props_u (
   .clk       (clk),
   .srst      (srst),
   .scl_in    (scl_in),
   .scl_out   (scl_out),
   .scl_oe_n  (scl_oe_n),
   .sda_in    (sda_in),
   .sda_out   (sda_out),
   .sda_oe_n  (sda_oe_n),
   .addr_sel  (addr_sel),
   .erase_busy(erase_busy)
);
`default_nettype wire

//--- tb_sre_smbus_mem.sv
// self-checking bench for the smbus ram/eeprom block
`timescale 1ns/1ns
`default_nettype none
`include "sre_map.vh"
module tb_sre_smbus_mem;
   logic       clk;
   logic       srst;
   logic [1:0] sel;
   logic [7:0] adr;
   wire        scl;
   wire        sda;
   wire        d_scl;
   wire        d_sda;
   wire        m_scl;
   wire        m_sda;
   wire        erase_busy;
   int         error_cnt;
   int         tests_run;
   // pulled-up open-drain lines
   assign scl = d_scl & m_scl;
   assign sda = d_sda & m_sda;
   assign adr = {`SRE_SLAVE_HI, sel, 1'b0};
   // short program time, yet slow enough to fill the fifo
   sre_smbus_mem #(
      .PROG_CYC (23'd1000),
      .ERASE_CYC(23'd2000)
   ) dut_u (
      .clk       (clk),
      .srst      (srst),
      .scl_in    (scl),
      .scl_out   (),
      .scl_oe_n  (d_scl),
      .sda_in    (sda),
      .sda_out   (),
      .sda_oe_n  (d_sda),
      .addr_sel  (sel),
      .erase_busy(erase_busy)
   );
   sre_master m_u (
      .clk     (clk),
      .scl     (scl),
      .sda     (sda),
      .scl_oe_n(m_scl),
      .sda_oe_n(m_sda)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      error_cnt += m_u.tmo;
      $display("mismatches %0d, checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // write: c, d0, then d1 counting up, every byte acked
   task automatic wr(input logic [7:0] c, d0, d1, input int n);
      logic       a;
      logic [7:0] b;
      m_u.start();
      m_u.wbyte(adr, a);
      for (int i = 0; i < n; i++) begin
         check({7'h0, a}, 8'h01);
         b = i == 0 ? c : i == 1 ? d0 : d1 + i[7:0] - 8'h02;
         m_u.wbyte(b, a);
      end
      check({7'h0, a}, 8'h01);
      m_u.stop();
   endtask
   task automatic rd(input logic [7:0] e);
      logic       a;
      logic [7:0] d;
      m_u.start();
      m_u.wbyte(adr | 8'h01, a);
      m_u.rbyte(1'b1, d);
      m_u.stop();
      check(d, e);
   endtask
   task automatic blkr(input logic [7:0] v, input int n);
      logic       a;
      logic [7:0] d;
      m_u.start();
      m_u.wbyte(adr, a);
      m_u.wbyte(`SRE_CMD_BLKRD, a);
      m_u.start();
      m_u.wbyte(adr | 8'h01, a);
      m_u.rbyte(1'b0, d);
      check(d, `SRE_BLKRD_COUNT);
      for (int i = 0; i < n; i++) begin
         m_u.rbyte(i == n - 1, d);
         check(d, v + i[7:0]);
      end
      m_u.stop();
   endtask
   task automatic probe(input logic [7:0] ab, input logic e);
      logic a;
      m_u.start();
      m_u.wbyte(ab, a);
      m_u.stop();
      check({7'h0, a}, {7'h0, e});
   endtask
   // ram at both ends of its space, read back via the pointer
   task automatic s_ram();
      wr(8'h00, 8'ha5, 8'h00, 2);
      wr(8'hdf, 8'h3c, 8'h00, 2);
      wr(8'h00, 8'h00, 8'h00, 1);
      rd(8'ha5);
      wr(8'hdf, 8'h00, 8'h00, 1);
      rd(8'h3c);
   endtask
   // a programmed cell keeps its byte
   task automatic s_ee();
      wr(8'hf8, 8'h20, 8'h55, 3);
      wr(8'hf8, 8'h40, 8'h77, 3);
      wr(8'hf8, 8'h20, 8'h66, 3);
      wr(8'hf8, 8'h40, 8'h00, 2);
      rd(8'h77);
      wr(8'hf8, 8'h20, 8'h00, 2);
      rd(8'h55);
   endtask
   // erase refused while disabled, then page 1 via an odd pointer
   task automatic s_erase();
      int n;
      wr(`SRE_CMD_ERASE, 8'h00, 8'h00, 1);
      rd(8'h55);
      wr(`SRE_UPDATE_CONFIG_OFS, 8'h04, 8'h00, 2);
      wr(8'hf8, 8'h3f, 8'h00, 2);
      wr(`SRE_CMD_ERASE, 8'h00, 8'h00, 1);
      check({7'h0, erase_busy}, 8'h01);
      probe(adr, 1'b0);
      n = 0;
      while (erase_busy && n < 8000) begin
         @(negedge clk);
         n++;
      end
      check({7'h0, erase_busy}, 8'h00);
      if (n == 8000) report_and_stop();
      wr(8'hf8, 8'h20, 8'h00, 2);
      rd(8'hff);
      wr(8'hf8, 8'h40, 8'h00, 2);
      rd(8'h77);
   endtask
   // blocks across a page edge and in ram
   task automatic s_blk();
      wr(8'hf8, 8'h5e, 8'h00, 2);
      wr(`SRE_CMD_BLKWR, 8'h03, 8'h11, 5);
      wr(8'hf8, 8'h5e, 8'h00, 2);
      blkr(8'h11, 3);
      wr(8'h20, 8'h00, 8'h00, 1);
      wr(`SRE_CMD_BLKWR, 8'h04, 8'h30, 6);
      wr(8'h20, 8'h00, 8'h00, 1);
      blkr(8'h30, 4);
   endtask
   // two blocks outrun the drain, the full fifo holds scl
   task automatic s_full();
      wr(8'hf8, 8'h80, 8'h00, 2);
      m_u.smax = 0;
      wr(`SRE_CMD_BLKWR, 8'h20, 8'h40, 34);
      wr(`SRE_CMD_BLKWR, 8'h14, 8'h60, 22);
      check({7'h0, m_u.smax > 500}, 8'h01);
      wr(8'hf8, 8'h80, 8'h00, 2);
      blkr(8'h40, 32);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // a master wait that ran out ends the run
   always @(posedge clk) begin
      if (m_u.tmo != 0) report_and_stop();
   end
   initial begin
      error_cnt = 0;
      tests_run = 0;
      srst = 1'b1;
      sel = 2'b10;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      repeat (8) @(negedge clk);
      s_ram();
      probe(adr, 1'b1);
      probe({`SRE_SLAVE_HI, ~sel, 1'b0}, 1'b0);
      s_ee();
      s_erase();
      s_blk();
      s_full();
      report_and_stop();
   end
endmodule
`default_nettype wire
